// >>> rtl/spindle_interval_speed_control.sv
// Purpose: interval counter, commutation delay and speed loop settings
// Assumes: zero_cross_i is an accepted, blanked crossing pulse
// Notes: apb slave, zero wait states
// Notes on behaviour
// - count ticks between consecutive zero crossings
// - interval count never exceeds programmed limit
// - commutation delay is half the interval
// - limit low bits forced to ones
// - phase loop added only when enabled
// - two-bit code selects pump current level
// - divisor from three upper, twelve lower bits
// - frequency loop is primary, twelve poles
// - discharge frequency pump while stopped
// - one 50% pulse per revolution when running
// - route bit steers shared dac
// - vcm code signed, most negative saturates
// - delay uses limit when interval reaches it
// - tick is clock over 4, 8, 16, 32
//
// Decided for this implementation: the APB register port and the register addresses.
`include "spindle_timing_defs.svh"
module spindle_interval_speed_control #(
    parameter int CNT_W = `CNT_W,
    parameter int LIM_LSB = `LIM_LSB
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic zero_cross_i,
    output logic tick_o,
    output logic [CNT_W-2:0] commutation_delay_o,
    output logic fll_enable_o,
    output logic fll_discharge_o,
    output logic phase_loop_enable_o,
    output logic [1:0] phase_pump_current_select_o,
    output logic [14:0] speed_divisor_o,
    output logic revolution_pulse_out_o,
    output logic [4:0] spin_dac_code_o,
    output logic [5:0] vcm_offset_code_o,
    output logic [1:0] dac_route_o
);
    logic [11:0] timing_ctrl;
    logic [`LIM_W-1:0] limit_field;
    logic [11:0] speed_hi;
    logic [11:0] speed_lo;
    logic hi_pending;
    logic lo_pending;
    logic [14:0] speed_divisor;
    logic [4:0] presc;
    logic [CNT_W-1:0] interval_counter;
    logic [CNT_W-1:0] measured;
    logic [CNT_W-2:0] comm_delay;
    logic [5:0] xing_count;
    logic rev_level;
    logic [4:0] spin_code;
    logic [5:0] vcm_code;

    // apb decode
    wire access = psel_i & penable_i;
    wire wr = access & pwrite_i;
    wire sel_ctrl = paddr_i == `OFS_TIMING_CTRL;
    wire sel_limit = paddr_i == `OFS_LIMIT;
    wire sel_hi = paddr_i == `OFS_SPEED_HI;
    wire sel_lo = paddr_i == `OFS_SPEED_LO;
    wire sel_status = paddr_i == `OFS_STATUS;
    wire sel_div = paddr_i == `OFS_DIVISOR;
    wire mapped = sel_ctrl | sel_limit | sel_hi | sel_lo | sel_status | sel_div;
    // status and divisor are read only; writing them is an error
    wire ro_write = pwrite_i & (sel_status | sel_div);
    wire wr_ctrl = wr & sel_ctrl;
    wire wr_limit = wr & sel_limit;
    wire wr_hi = wr & sel_hi;
    wire wr_lo = wr & sel_lo;

    wire run = timing_ctrl[`RUN_BIT];
    spindle_timing_pkg::prescale_sel_t presc_sel;
    assign presc_sel = timing_ctrl[`PRESC_MSB:`PRESC_LSB];

    // low bits of the limit are always ones
    wire [CNT_W-1:0] eff_limit = {limit_field, {LIM_LSB{1'b1}}};
    wire at_limit = interval_counter >= eff_limit;
    // clamp on the write edge so the count never sits above the new limit
    wire [CNT_W-1:0] wr_limit_val = {pwdata_i[`LIM_W-1:0], {LIM_LSB{1'b1}}};
    wire lim_drop = wr_limit && interval_counter >= wr_limit_val;

    // tick mask 3/7/15/31 picks divide by 4/8/16/32
    wire [4:0] presc_mask = presc_sel == 2'h0 ? 5'h03 :
                            presc_sel == 2'h1 ? 5'h07 :
                            presc_sel == 2'h2 ? 5'h0F : 5'h1F;
    wire tick = (presc & presc_mask) == presc_mask;

    // crossing captures the interval, capped by the limit
    wire [CNT_W-1:0] capped = at_limit ? eff_limit : interval_counter;
    wire [CNT_W-2:0] next_delay = capped[CNT_W-1:1];

    wire commit = hi_pending & lo_pending;
    wire [14:0] next_divisor = {speed_hi[`SPD_UP_MSB:`SPD_UP_LSB],
                                speed_lo[`SPD_LO_MSB:0]};

    wire rev_wrap = xing_count == (`XINGS_HALF_REV - 6'h01);

    wire route_vcm = speed_hi[`ROUTE_BIT];
    wire [5:0] dac_code = speed_hi[`DAC_MSB:`DAC_LSB];
    // 100000 has no positive twin, so it drives the same as 100001
    wire [5:0] next_vcm = dac_code == `VCM_NEG_FULL ? `VCM_NEG_SAT :
                          dac_code;
    // host keeps spindle codes positive; sign bit is simply dropped
    wire [4:0] next_spin = dac_code[4:0];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            timing_ctrl <= `RST_CTRL;
            limit_field <= `RST_LIMIT;
            speed_hi <= `RST_SPEED_HI;
            speed_lo <= `RST_SPEED_LO;
        end else begin
            if (wr_ctrl) begin
                timing_ctrl <= pwdata_i[11:0];
            end
            if (wr_limit) begin
                limit_field <= pwdata_i[`LIM_W-1:0];
            end
            if (wr_hi) begin
                speed_hi <= pwdata_i[11:0];
            end
            if (wr_lo) begin
                speed_lo <= pwdata_i[11:0];
            end
        end
    end

    // a write landing on the commit cycle keeps its pending flag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hi_pending <= 1'b0;
            lo_pending <= 1'b0;
            speed_divisor <= 15'h0000;
        end else begin
            hi_pending <= wr_hi | (hi_pending & ~commit);
            lo_pending <= wr_lo | (lo_pending & ~commit);
            if (commit) begin
                speed_divisor <= next_divisor;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            presc <= 5'h00;
        end else begin
            presc <= presc + 5'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            interval_counter <= '0;
            measured <= '0;
            comm_delay <= '0;
        end else if (zero_cross_i) begin
            interval_counter <= '0;
            measured <= capped;
            comm_delay <= next_delay;
        end else if (lim_drop) begin
            // a lowered limit pulls the count down on the write edge
            interval_counter <= wr_limit_val;
        end else if (tick && !at_limit) begin
            interval_counter <= CNT_W'(interval_counter + 1'b1);
        end
    end

    // 36 crossings per turn; toggling every 18 gives 50% duty
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run) begin
            xing_count <= 6'h00;
            rev_level <= 1'b0;
        end else if (zero_cross_i) begin
            xing_count <= rev_wrap ? 6'h00 : xing_count + 6'h01;
            rev_level <= rev_wrap ? ~rev_level : rev_level;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            spin_code <= 5'h00;
            vcm_code <= 6'h00;
        end else begin
            spin_code <= route_vcm ? 5'h00 : next_spin;
            vcm_code <= route_vcm ? next_vcm : 6'h00;
        end
    end

    // read mux
    wire [31:0] rd_ctrl = {20'h00000, timing_ctrl};
    wire [31:0] rd_limit = {{(32-`LIM_W){1'b0}}, limit_field};
    wire [31:0] rd_hi = {20'h00000, speed_hi};
    wire [31:0] rd_lo = {20'h00000, speed_lo};
    wire [31:0] rd_status = {4'h0, measured, 4'h0, 1'b0, comm_delay};
    wire [31:0] rd_div = {15'h0000, commit | hi_pending | lo_pending,
                          1'b0, speed_divisor};
    assign prdata_o = sel_ctrl ? rd_ctrl :
                      sel_limit ? rd_limit :
                      sel_hi ? rd_hi :
                      sel_lo ? rd_lo :
                      sel_status ? rd_status :
                      sel_div ? rd_div : 32'h00000000;
    assign pready_o = 1'b1;
    assign pslverr_o = access & (~mapped | ro_write);

    assign tick_o = tick;
    assign commutation_delay_o = comm_delay;
    // frequency loop regulates whenever the spindle runs
    assign fll_enable_o = run;
    assign fll_discharge_o = ~run;
    assign phase_loop_enable_o = run & speed_hi[`PLL_EN_BIT];
    assign phase_pump_current_select_o = speed_hi[`PUMP_MSB:`PUMP_LSB];
    assign speed_divisor_o = speed_divisor;
    assign revolution_pulse_out_o = rev_level;
    assign spin_dac_code_o = spin_code;
    assign vcm_offset_code_o = vcm_code;
    assign dac_route_o = route_vcm ? spindle_timing_pkg::ROUTE_VCM :
                         spindle_timing_pkg::ROUTE_SPINDLE;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    interval_cap_a: assert property (
        interval_counter <= eff_limit)
        else $error("interval counter above limit");
    crossing_clear_a: assert property (
        zero_cross_i |=> interval_counter == '0)
        else $error("crossing did not clear counter");
    delay_half_a: assert property (
        zero_cross_i |=> comm_delay ==
            (($past(interval_counter) >= $past(eff_limit) ?
              $past(eff_limit) : $past(interval_counter)) >> 1))
        else $error("commutation delay not half interval");
    tick_space_a: assert property (
        tick && presc_sel == 2'h0 && $stable(presc_sel)
        |=> (!tick)[*3])
        else $error("tick too early");
    discharge_stop_a: assert property (
        fll_discharge_o == !run)
        else $error("discharge not tied to run");
    rev_stopped_a: assert property (
        !$past(run) |-> !revolution_pulse_out_o)
        else $error("revolution pulse while stopped");
    divisor_hold_a: assert property (
        !commit |=> $stable(speed_divisor))
        else $error("divisor changed without both words");
    vcm_sat_a: assert property (
        route_vcm && dac_code == `VCM_NEG_FULL && $stable(speed_hi)
        |=> vcm_code == `VCM_NEG_SAT)
        else $error("vcm most negative code not saturated");
    route_spin_a: assert property (
        !route_vcm && $stable(speed_hi) |=> vcm_code == 6'h00)
        else $error("vcm offset driven while routed to spindle");
    pll_gate_a: assert property (
        wr_hi && !pwdata_i[`PLL_EN_BIT] |=> !phase_loop_enable_o)
        else $error("phase loop on without enable");
    limit_ones_a: assert property (
        at_limit |-> interval_counter[LIM_LSB-1:0] == {LIM_LSB{1'b1}})
        else $error("limit low bits not ones");
endmodule

// >>> rtl/spindle_timing_defs.svh
`ifndef SPINDLE_TIMING_DEFS_SVH
`define SPINDLE_TIMING_DEFS_SVH
// register byte offsets
`define OFS_TIMING_CTRL 12'h000
`define OFS_LIMIT 12'h004
`define OFS_SPEED_HI 12'h008
`define OFS_SPEED_LO 12'h00C
`define OFS_STATUS 12'h010
`define OFS_DIVISOR 12'h014
// timing control fields
`define RUN_BIT 0
`define PRESC_MSB 8
`define PRESC_LSB 7
// speed-high word fields
`define SPD_UP_MSB 11
`define SPD_UP_LSB 9
`define PLL_EN_BIT 9
`define PUMP_MSB 8
`define PUMP_LSB 7
`define ROUTE_BIT 6
`define DAC_MSB 5
`define DAC_LSB 0
// speed-low word field
`define SPD_LO_MSB 11
// interval counter layout
`define CNT_W 12
`define LIM_LSB 6
`define LIM_W 6
// reset values
`define RST_CTRL 12'h000
`define RST_LIMIT 6'h3F
`define RST_SPEED_HI 12'h000
`define RST_SPEED_LO 12'h000
// zero crossings per motor revolution, twelve poles, and half of it
`define XINGS_PER_REV 6'h24
`define XINGS_HALF_REV 6'h12
// vcm offset codes
`define VCM_NEG_FULL 6'h20
`define VCM_NEG_SAT 6'h21
`endif

// >>> rtl/spindle_timing_pkg.sv
// Purpose: shared types of the spindle interval and speed block
// Assumes: nothing beyond the defs header
// Notes: constants live in spindle_timing_defs.svh
package spindle_timing_pkg;
    typedef logic [1:0] prescale_sel_t;
    typedef logic [1:0] pump_sel_t;
    typedef enum logic [1:0] {
        ROUTE_SPINDLE = 2'b01,
        ROUTE_VCM = 2'b10
    } dac_route_t;
endpackage

// >>> tb/spindle_motor_model.sv
// Purpose: spinning motor seen through its accepted zero crossings
// Assumes: crossings already blanked, one clock wide
// Notes: period in clocks, crossing count per burst
module spindle_motor_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [15:0] period_i,
    input wire logic [7:0] count_i,
    output logic zero_cross_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] wait_cnt;
    logic [7:0] left;
    assign busy_o = (left != 8'h00);
    // steady speed: fixed spacing keeps crossings off the tick edges
    always_ff @(posedge clk_i) begin
        zero_cross_o <= 1'b0;
        if (rst_i) begin
            left <= 8'h00;
            wait_cnt <= 16'h0000;
        end else if (start_i) begin
            left <= count_i;
            wait_cnt <= period_i;
        end else if (busy_o && wait_cnt == 16'h0001) begin
            zero_cross_o <= 1'b1;
            left <= left - 8'h01;
            wait_cnt <= period_i;
        end else if (busy_o) begin
            wait_cnt <= wait_cnt - 16'h0001;
        end
    end
endmodule

// >>> tb/testbench.sv
// Purpose: self-checking bench of the interval and speed block
// Assumes: zero wait state apb slave
// Notes: results queue up, a monitor compares them in order
`include "spindle_timing_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, start = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, v;
    logic [15:0] period = 16'h0008;
    logic [7:0] count = 8'h00;
    logic pready, pslverr, zc, busy, tick, fll_en, fll_dis, ple, rev;
    logic [10:0] dly;
    logic [1:0] pump, route;
    logic [14:0] div, d;
    logic [4:0] spin;
    logic [5:0] vcm;
    logic [32:0] r, g, e, exp_q[$], got_q[$];
    int failures = 0, cmp_count = 0, k, n, lim;
    spindle_interval_speed_control dut (.core_clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .zero_cross_i(zc),
        .tick_o(tick), .commutation_delay_o(dly), .fll_enable_o(fll_en),
        .fll_discharge_o(fll_dis), .phase_loop_enable_o(ple),
        .phase_pump_current_select_o(pump), .speed_divisor_o(div),
        .revolution_pulse_out_o(rev), .spin_dac_code_o(spin),
        .vcm_offset_code_o(vcm), .dac_route_o(route));
    spindle_motor_model motor (.clk_i(clk), .rst_i(rst), .start_i(start),
        .period_i(period), .count_i(count), .zero_cross_o(zc),
        .busy_o(busy));
    initial forever #5 clk = ~clk;
    task automatic print_verdict();
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic bail();
        failures++;
        print_verdict();
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] want);
        got_q.push_back(got);
        exp_q.push_back(want);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) bail();
    endtask
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (tick !== 1'b1 && c < 100);
        if (tick !== 1'b1) bail();
    endtask
    // start one tick edge late so no crossing lands on a count edge
    task automatic burst(input int p, input int c);
        int i;
        wait_tick(i);
        @(posedge clk);
        period <= 16'(p);
        count <= 8'(c);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (busy !== 1'b0 && i < 30000);
        if (busy !== 1'b0) bail();
        repeat (2) @(posedge clk);
    endtask
    initial forever begin
        @(posedge clk);
        while (got_q.size() > 0) begin
            g = got_q.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        bail();
    end
    initial begin
        v = $urandom(24465);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `OFS_LIMIT, 32'h0);
        check(r, 33'h3F);
        check(33'({fll_en, fll_dis, route}), 33'h5);
        apb(1'b0, 12'h040, 32'h0);
        check(r, 33'h100000000);
        apb(1'b1, `OFS_STATUS, 32'hFFF);
        check(33'(r[32]), 33'h1);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `OFS_TIMING_CTRL, 32'((k << 7) | 1));
            wait_tick(n);
            wait_tick(n);
            check(33'(n), 33'(4 << k));
            check(33'({fll_en, fll_dis}), 33'h2);
        end
        apb(1'b1, `OFS_TIMING_CTRL, 32'h1);
        for (k = 0; k < 6; k++) begin
            n = (k < 2) ? 20 + 80 * k : 5 + $urandom % 200;
            lim = (k < 2) ? 63 : ((k % 2) << 6) | 63;
            apb(1'b1, `OFS_LIMIT, 32'(lim >> 6));
            burst(4 * n, 3);
            n = (n < lim) ? n : lim;
            apb(1'b0, `OFS_STATUS, 32'h0);
            check(33'(r[27:16]), 33'(n));
            check(33'(dly), 33'(n >> 1));
        end
        apb(1'b1, `OFS_TIMING_CTRL, 32'h0);
        apb(1'b1, `OFS_TIMING_CTRL, 32'h1);
        burst(8, 17);
        check(33'(rev), 33'h0);
        burst(8, 1);
        check(33'(rev), 33'h1);
        d = 15'(80000000 / (3 * 5400));
        apb(1'b1, `OFS_SPEED_HI, 32'({d[14:12], 9'h000}));
        repeat (2) @(posedge clk);
        check(33'(div), 33'h0);
        apb(1'b1, `OFS_SPEED_LO, 32'(d[11:0]));
        repeat (2) @(posedge clk);
        check(33'(div), 33'(d));
        apb(1'b1, `OFS_SPEED_LO, 32'h5);
        repeat (2) @(posedge clk);
        check(33'(div), 33'(d));
        for (k = 0; k < 6; k++) begin
            v = $urandom & 32'hFFF;
            v[8:7] = 2'(k);
            if (k == 4) v[6:0] = 7'h60;
            if (k == 5) v[6:0] = 7'h5F;
            if (!v[6]) v[5] = 1'b0;
            apb(1'b1, `OFS_SPEED_HI, v);
            repeat (2) @(posedge clk);
            check(33'({ple, pump, route}),
                33'({v[9], v[8:7], v[6] ? 2'b10 : 2'b01}));
            check(33'({spin, vcm}),
                33'({v[6] ? 5'h00 : v[4:0], !v[6] ? 6'h00 :
                (v[5:0] == 6'h20 ? 6'h21 : v[5:0])}));
        end
        apb(1'b1, `OFS_SPEED_HI, 32'h200);
        apb(1'b1, `OFS_TIMING_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        check(33'({ple, fll_en, fll_dis, rev}), 33'h2);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
